//--- hdl/smc_consts.vh
// Constants shared by the static memory cycle controller files.
// Assumes inclusion by bare name from files under hdl/.
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// Structure sizes
`define SMC_PORTS          3
`define SMC_CS_COUNT       4
`define SMC_CS_W           2
`define SMC_ADDR_W         24
`define SMC_DATA_W         16
`define SMC_CNT_W          4
`define SMC_AVD_W          2
`define SMC_GAP_W          6
`define SMC_PAGE_BITS      4

// Port indices
`define SMC_PORT_PROC0     2'h0
`define SMC_PORT_PROC1     2'h1
`define SMC_PORT_GRAPHICS  2'h2

// Least settings the cycle engine enforces
`define SMC_MIN_INITIAL    4'h1
`define SMC_MIN_TAIL       4'h1
`define SMC_MIN_PAGE_WAIT  4'h1

// Reset values
`define SMC_RST_CNT        6'h00
`define SMC_RST_ADDR       24'h000000
`define SMC_RST_DATA       16'h0000
`define SMC_RST_CS         2'h0

`endif

//--- hdl/smc_arbiter.v
// Three-port fixed/programmable priority arbiter for the memory cycle engine.
// Assumes requests are levels from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_arbiter
(
  input  wire [2:0] i_request,
  input  wire       i_processor1_first,
  output reg  [2:0] o_grant,
  output reg  [1:0] o_index
);

  // Graphics port only wins when no processor asks
  always @*
  begin
    o_grant = 3'h0;
    o_index = `SMC_PORT_PROC0;
    if (i_processor1_first && i_request[1])
    begin
      o_grant = 3'h2;
      o_index = `SMC_PORT_PROC1;
    end
    else if (i_request[0])
    begin
      o_grant = 3'h1;
      o_index = `SMC_PORT_PROC0;
    end
    else if (i_request[1])
    begin
      o_grant = 3'h2;
      o_index = `SMC_PORT_PROC1;
    end
    else if (i_request[2])
    begin
      o_grant = 3'h4;
      o_index = `SMC_PORT_GRAPHICS;
    end
  end

endmodule
`default_nettype wire

//--- hdl/smc_core.v
// Cycle-timing core of a 16-bit external static memory controller.
// Assumes: masters on i_clock, memory data bus sampled on i_clock,
// stall pin asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_core
#(
  parameter AW = `SMC_ADDR_W,
  parameter DW = `SMC_DATA_W,
  parameter CW = `SMC_CNT_W,
  parameter PB = `SMC_PAGE_BITS
)
(
  input  wire                   i_clock,
  input  wire                   i_reset,
  // Master ports, index 0/1 processors, 2 graphics
  input  wire [2:0]             i_request,
  input  wire [2:0]             i_write,
  input  wire [5:0]             i_chip_select,
  input  wire [3*AW-1:0]        i_address,
  input  wire [3*DW-1:0]        i_write_data,
  output wire [2:0]             o_accept,
  output reg  [2:0]             o_read_valid,
  output reg  [DW-1:0]          o_read_data,
  input  wire                   i_processor1_first,
  // Per chip select configuration, four fields packed low to high
  input  wire [4*CW-1:0]        i_initial_latency_rd,
  input  wire [4*CW-1:0]        i_initial_latency_wr,
  input  wire [4*CW-1:0]        i_access_latency_rd,
  input  wire [4*CW-1:0]        i_access_latency_wr,
  input  wire [4*CW-1:0]        i_write_tail_cycles,
  input  wire [4*CW-1:0]        i_turnaround_cycles,
  input  wire [4*CW-1:0]        i_precharge_cycles,
  input  wire [7:0]             i_addr_valid_idle_cycles,
  input  wire [3:0]             i_addr_valid_idle_level,
  input  wire [3:0]             i_page_read_enable,
  input  wire [3:0]             i_page_write_enable,
  input  wire [3:0]             i_burst_capable,
  input  wire [3:0]             i_burst_read_enable,
  input  wire                   i_pseudo_static_config_request,
  // Memory pins
  output wire [3:0]             o_chip_select_n,
  output wire                   o_output_enable_n,
  output wire                   o_write_enable_n,
  output reg  [AW-1:0]          o_address,
  output reg  [DW-1:0]          o_data_out,
  output wire                   o_data_oe,
  input  wire [DW-1:0]          i_data_in,
  output wire                   o_addr_valid_strobe_n,
  output reg                    o_burst_memory_clock,
  input  wire                   i_memory_stall_in_n,
  output reg                    o_pseudo_static_config_enable,
  output wire                   o_busy
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_GAP  = 5'h02;
  localparam [4:0] ST_INIT = 5'h04;
  localparam [4:0] ST_ACC  = 5'h08;
  localparam [4:0] ST_TAIL = 5'h10;

  reg  [4:0]              state;
  reg  [4:0]              next_state;
  reg  [`SMC_GAP_W-1:0]   cnt;
  reg  [`SMC_GAP_W-1:0]   next_cnt;
  reg  [1:0]              cs;
  reg                     wr;
  reg                     last_valid;
  reg  [1:0]              port;
  reg  [CW-1:0]           cur_init;
  reg  [CW-1:0]           cur_wait;
  reg  [CW-1:0]           cur_tail;
  reg                     avd_first;
  reg                     stall_meta_n;
  reg                     stall_sync_n;

  wire [2:0]              g_one;
  wire [1:0]              g_idx;
  wire                    g_any;

  smc_arbiter u_arbiter
  (
    .i_request          (i_request),
    .i_processor1_first (i_processor1_first),
    .o_grant            (g_one),
    .o_index            (g_idx)
  );

  assign g_any = |g_one;

  // Candidate request fields from the granted port
  wire [1:0]    n_cs   = i_chip_select[{g_idx, 1'b0} +: 2];
  wire          n_wr   = i_write[g_idx];
  wire [AW-1:0] n_addr = i_address[g_idx * AW +: AW];
  wire [DW-1:0] n_data = i_write_data[g_idx * DW +: DW];

  // Settings of the candidate's chip select only
  wire [CW-1:0] n_init = n_wr ? i_initial_latency_wr[n_cs * CW +: CW]
                              : i_initial_latency_rd[n_cs * CW +: CW];
  wire [CW-1:0] n_wait = n_wr ? i_access_latency_wr[n_cs * CW +: CW]
                              : i_access_latency_rd[n_cs * CW +: CW];
  wire [CW-1:0] n_tail = i_write_tail_cycles[n_cs * CW +: CW];
  wire [CW-1:0] n_turn = i_turnaround_cycles[n_cs * CW +: CW];
  wire [CW-1:0] n_pre  = i_precharge_cycles[n_cs * CW +: CW];
  wire [1:0]    n_avd  = i_addr_valid_idle_cycles[{n_cs, 1'b0} +: 2];
  wire          n_page = n_wr ? i_page_write_enable[n_cs]
                              : i_page_read_enable[n_cs];

  // Least settings forced by the engine
  wire [CW-1:0] n_init_eff = (n_init < `SMC_MIN_INITIAL) ? `SMC_MIN_INITIAL : n_init;
  wire [CW-1:0] n_tail_eff = (n_tail < `SMC_MIN_TAIL) ? `SMC_MIN_TAIL : n_tail;
  wire          pg_wr_min  = n_wr && n_page && (n_wait < `SMC_MIN_PAGE_WAIT);
  wire [CW-1:0] n_wait_eff = pg_wr_min ? `SMC_MIN_PAGE_WAIT : n_wait;

  // Relation of the candidate to the previous access
  wire same_cs    = last_valid && (n_cs == cs);
  wire same_page  = (n_addr[AW-1:PB] == o_address[AW-1:PB]);
  wire page_hit   = same_cs && (n_wr == wr) && n_page && same_page;
  wire turn_apply = last_valid && !wr && ((n_cs != cs) || n_wr);
  wire pre_apply  = same_cs && (!n_page || !same_page);
  wire avd_apply  = i_burst_capable[n_cs] && last_valid
                    && ((n_cs != cs) || (n_wr != wr));

  wire [`SMC_GAP_W-1:0] turn_c = turn_apply ? {2'b00, n_turn} : `SMC_RST_CNT;
  wire [`SMC_GAP_W-1:0] pre_c  = pre_apply ? {2'b00, n_pre} : `SMC_RST_CNT;
  wire [`SMC_GAP_W-1:0] avd_c  = avd_apply ? {4'h0, n_avd} : `SMC_RST_CNT;
  wire [`SMC_GAP_W-1:0] gap_c  = turn_c + pre_c + avd_c;

  // Stall is honoured only on burst reads once counters are spent
  wire burst_rd   = i_burst_read_enable[cs] && !wr;
  wire stall_hold = burst_rd && !stall_sync_n;
  wire acc_end    = state[3] && (cnt == `SMC_RST_CNT) && !stall_hold;
  wire tail_end   = state[4] && (cnt == `SMC_RST_CNT);
  wire cont_point = (acc_end && !wr) || tail_end;
  wire take_idle  = state[0] && g_any;
  wire take_cont  = cont_point && g_any && page_hit;
  wire take       = take_idle || take_cont;

  assign o_accept = g_one & {3{take}};

  // Next state and counter
  always @*
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE:
      begin
        // The idle cycle is the arbitration cycle
        if (g_any)
        begin
          if (gap_c != `SMC_RST_CNT)
          begin
            next_state = ST_GAP;
            next_cnt   = gap_c - 6'h01;
          end
          else
          begin
            next_state = ST_INIT;
            next_cnt   = {2'b00, n_init_eff} - 6'h01;
          end
        end
      end
      ST_GAP:
      begin
        if (cnt == `SMC_RST_CNT)
        begin
          next_state = ST_INIT;
          next_cnt   = {2'b00, cur_init} - 6'h01;
        end
        else
          next_cnt = cnt - 6'h01;
      end
      ST_INIT:
      begin
        if (cnt == `SMC_RST_CNT)
        begin
          next_state = ST_ACC;
          next_cnt   = {2'b00, cur_wait};
        end
        else
          next_cnt = cnt - 6'h01;
      end
      ST_ACC:
      begin
        if (cnt != `SMC_RST_CNT)
          next_cnt = cnt - 6'h01;
        else if (stall_hold)
          next_cnt = cnt;
        else if (wr)
        begin
          next_state = ST_TAIL;
          next_cnt   = {2'b00, cur_tail} - 6'h01;
        end
        else if (take_cont)
        begin
          next_state = ST_ACC;
          next_cnt   = {2'b00, n_wait_eff};
        end
        else
          next_state = ST_IDLE;
      end
      ST_TAIL:
      begin
        if (cnt != `SMC_RST_CNT)
          next_cnt = cnt - 6'h01;
        else if (take_cont)
        begin
          next_state = ST_ACC;
          next_cnt   = {2'b00, n_wait_eff};
        end
        else
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
        next_cnt   = `SMC_RST_CNT;
      end
    endcase
  end

  // State, counter and accepted request
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state      <= ST_IDLE;
      cnt        <= `SMC_RST_CNT;
      cs         <= `SMC_RST_CS;
      wr         <= 1'b0;
      port       <= `SMC_PORT_PROC0;
      last_valid <= 1'b0;
      cur_init   <= `SMC_MIN_INITIAL;
      cur_wait   <= {CW{1'b0}};
      cur_tail   <= `SMC_MIN_TAIL;
      avd_first  <= 1'b0;
      o_address  <= `SMC_RST_ADDR;
      o_data_out <= `SMC_RST_DATA;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (take)
      begin
        cs         <= n_cs;
        wr         <= n_wr;
        port       <= g_idx;
        last_valid <= 1'b1;
        cur_init   <= n_init_eff;
        cur_wait   <= n_wait_eff;
        cur_tail   <= n_tail_eff;
        o_address  <= n_addr;
        o_data_out <= n_data;
      end
      // First cycle of a fresh access carries the address-valid pulse
      avd_first <= (next_state == ST_INIT) && !state[2];
    end
  end

  // Read data capture and per-port completion pulse
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_read_valid <= 3'h0;
      o_read_data  <= `SMC_RST_DATA;
    end
    else
    begin
      o_read_valid <= 3'h0;
      if (acc_end && !wr)
      begin
        o_read_data  <= i_data_in;
        o_read_valid <= 3'h1 << port;
      end
    end
  end

  // Two-flop synchroniser for the stall pin
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      stall_meta_n <= 1'b1;
      stall_sync_n <= 1'b1;
    end
    else
    begin
      stall_meta_n <= i_memory_stall_in_n;
      stall_sync_n <= stall_meta_n;
    end
  end

  // Burst clock divider and pseudo-static configuration pin
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_burst_memory_clock          <= 1'b0;
      o_pseudo_static_config_enable <= 1'b0;
    end
    else
    begin
      o_burst_memory_clock          <= (|i_burst_read_enable) && !o_burst_memory_clock;
      o_pseudo_static_config_enable <= i_pseudo_static_config_request;
    end
  end

  // Memory strobes; tail keeps the select low with the write strobe high
  wire strobe = state[2] || state[3];
  wire active = strobe || state[4];

  assign o_chip_select_n   = active ? ~(4'h1 << cs) : 4'hF;
  assign o_output_enable_n = !(strobe && !wr);
  assign o_write_enable_n  = !(strobe && wr);
  assign o_data_oe         = strobe && wr;
  assign o_busy            = !state[0];

  // Address-valid: held low in async mode, one pulse in burst mode
  wire avd_level = i_addr_valid_idle_level[cs];
  wire avd_async = i_burst_capable[cs] && !burst_rd && strobe;
  wire avd_burst = i_burst_capable[cs] && burst_rd && avd_first;
  assign o_addr_valid_strobe_n = state[1] ? 1'b1
                               : (avd_async || avd_burst) ? 1'b0
                               : avd_level;

endmodule
`default_nettype wire

//--- verif/smc_core_asserts.sv
// Checker for smc_core: strobe lengths, gaps between accesses, priority.
// Assumes it is bound to smc_core and that everything runs on i_clock.
`timescale 1ns/1ps
`default_nettype none

module smc_checker
(
  input wire logic       i_clock,
  input wire logic       i_reset,
  input wire logic [2:0] i_request,
  input wire logic       i_processor1_first,
  input wire logic [2:0] o_accept,
  input wire logic [2:0] o_read_valid,
  input wire logic [3:0] o_chip_select_n,
  input wire logic       o_output_enable_n,
  input wire logic       o_write_enable_n,
  input wire logic       o_data_oe,
  input wire logic       o_addr_valid_strobe_n,
  input wire logic       o_busy,
  input wire logic [3:0] i_burst_capable,
  input wire logic [3:0] i_burst_read_enable
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // A strobe must stay low for two cycles at least
  sequence s_rd2;
    !o_output_enable_n ##1 !o_output_enable_n;
  endsequence
  sequence s_wr2;
    !o_write_enable_n ##1 !o_write_enable_n;
  endsequence

  a_read_min_len: assert property ($fell(o_output_enable_n) |-> s_rd2)
    else $error("Read strobe too short");
  a_write_min_len: assert property ($fell(o_write_enable_n) |-> s_wr2)
    else $error("Write strobe too short");
  a_tail_hold: assert property ($rose(o_write_enable_n) |-> !(&o_chip_select_n))
    else $error("Select dropped without a tail cycle");
  a_data_drive: assert property (o_data_oe == !o_write_enable_n)
    else $error("Data driven outside the write strobe");
  a_select_gap: assert property (|(~$past(o_chip_select_n) & o_chip_select_n)
    |-> &o_chip_select_n)
    else $error("Select switched with no idle cycle");
  a_gap_avd_high: assert property (o_busy && &o_chip_select_n |-> o_addr_valid_strobe_n)
    else $error("Address valid low in a gap");
  a_graphics_last: assert property (o_accept[2] |-> !(|i_request[1:0]))
    else $error("Graphics port taken over a processor");
  a_proc_order: assert property (o_accept[0] && i_request[1] |-> !i_processor1_first)
    else $error("Processor order ignored");
  a_valid_after: assert property (|o_read_valid |-> !$past(o_output_enable_n))
    else $error("Read completion without a read strobe");

  // Select 0 in asynchronous mode keeps address valid low while its read strobe is low
  a_avd_async_low: assert property (i_burst_capable[0] && !i_burst_read_enable[0]
    && !o_chip_select_n[0] && !o_output_enable_n |-> !o_addr_valid_strobe_n)
    else $error("Address valid not held low in asynchronous mode");
  // Select 0 in burst read mode gives a single-cycle address valid pulse
  a_avd_one_pulse: assert property (i_burst_read_enable[0] && !o_chip_select_n[0]
    && !o_output_enable_n && $fell(o_addr_valid_strobe_n) |=> o_addr_valid_strobe_n)
    else $error("Address valid pulse longer than one cycle");
endmodule

`default_nettype wire

//--- verif/smc_mem_model.sv
// Far-side 16-bit memory: 256 words, reads on the strobe, optional stall.
// Assumes the strobes of smc_core, sampled on i_clock.
`timescale 1ns/1ps
`default_nettype none

module smc_mem_model
(
  input  wire logic        i_clock,
  input  wire logic [3:0]  i_chip_select_n,
  input  wire logic        i_output_enable_n,
  input  wire logic        i_write_enable_n,
  input  wire logic [23:0] i_address,
  input  wire logic [15:0] i_data,
  input  wire logic        i_data_oe,
  input  wire logic [3:0]  i_stall_cycles,
  output wire logic [15:0] o_data,
  output wire logic        o_stall_n
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic [3:0]  cnt = 4'h0;
  logic        oe_q = 1'b1;
  wire  [7:0]  idx;
  wire         sel;

  // Known content so reads are predictable
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'h5A00 | 16'(i);
  end

  // Word index from select number and low address
  assign idx = {~i_chip_select_n[3] | ~i_chip_select_n[2],
                ~i_chip_select_n[3] | ~i_chip_select_n[1], i_address[5:0]};
  assign sel = !(&i_chip_select_n);
  // Released bus shows a changing pattern, not the last word
  assign o_data = (!i_output_enable_n && sel) ? mem[idx] : ~last;
  assign o_stall_n = (cnt == 4'h0);

  // Store writes, start a stall at the read strobe edge
  always @(posedge i_clock)
  begin
    last <= o_data;
    oe_q <= i_output_enable_n;
    if (!i_write_enable_n && i_data_oe && sel)
      mem[idx] <= i_data;
    if (oe_q && !i_output_enable_n)
      cnt <= i_stall_cycles;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
endmodule

`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for smc_core with the far-side memory model.
// Assumes design files under hdl/, model and checker under verif/.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
  logic        i_clock = 1'b0, i_reset = 1'b1, i_processor1_first = 1'b0;
  logic [2:0]  i_request = 3'h0, i_write = 3'h0;
  logic [5:0]  i_chip_select = 6'h00;
  logic [71:0] i_address = 72'h0;
  logic [47:0] i_write_data = 48'h0;
  logic [15:0] i_initial_latency_rd = 16'h0, i_access_latency_rd = 16'h0;
  logic [15:0] i_write_tail_cycles = 16'h0, i_turnaround_cycles = 16'h0;
  logic [15:0] i_precharge_cycles = 16'h0;
  logic [7:0]  i_addr_valid_idle_cycles = 8'h00;
  logic [3:0]  i_page_read_enable = 4'h0, i_page_write_enable = 4'h0, stall = 4'h0;
  logic [3:0]  i_burst_capable = 4'h0, i_burst_read_enable = 4'h0;
  logic [3:0]  lvl = 4'hF;
  logic        cre = 1'b0, bclk;
  wire  [2:0]  o_accept, o_read_valid;
  wire  [15:0] o_read_data, o_data_out, i_data_in;
  wire  [23:0] o_address;
  wire  [3:0]  o_chip_select_n;
  wire         o_output_enable_n, o_write_enable_n, o_data_oe;
  wire         o_addr_valid_strobe_n, i_memory_stall_in_n, o_busy;
  wire         o_burst_memory_clock, o_pseudo_static_config_enable;
  logic [15:0] rdat [0:2];
  logic [5:0]  ord;
  int          checked = 0, bad_count = 0, nb, n1, cyc = 0;

  smc_core u_smc_core
  (
    .i_clock, .i_reset, .i_request, .i_write, .i_chip_select, .i_address, .i_write_data,
    .o_accept, .o_read_valid, .o_read_data, .i_processor1_first, .i_initial_latency_rd,
    .i_initial_latency_wr(i_initial_latency_rd), .i_access_latency_rd,
    .i_access_latency_wr(i_access_latency_rd), .i_write_tail_cycles, .i_turnaround_cycles,
    .i_precharge_cycles, .i_addr_valid_idle_cycles, .i_addr_valid_idle_level(lvl),
    .i_page_read_enable, .i_page_write_enable, .i_burst_capable, .i_burst_read_enable,
    .i_pseudo_static_config_request(cre), .o_chip_select_n, .o_output_enable_n,
    .o_write_enable_n, .o_address, .o_data_out, .o_data_oe, .i_data_in,
    .o_addr_valid_strobe_n, .o_burst_memory_clock, .i_memory_stall_in_n,
    .o_pseudo_static_config_enable, .o_busy
  );

  smc_mem_model u_smc_mem_model
  (
    .i_clock, .i_chip_select_n(o_chip_select_n), .i_output_enable_n(o_output_enable_n),
    .i_write_enable_n(o_write_enable_n), .i_address(o_address), .i_data(o_data_out),
    .i_data_oe(o_data_oe), .i_stall_cycles(stall), .o_data(i_data_in),
    .o_stall_n(i_memory_stall_in_n)
  );

  always #5 i_clock = ~i_clock;

  // Verdict and end of run
  task end_sim;
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      bad_count++;
      end_sim;
    end
  end

  // Load one port's request fields
  task automatic setp(input int p, input logic w, input logic [1:0] c,
                      input logic [23:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_write[p] <= w;
    i_chip_select[2*p+:2] <= c;
    i_address[24*p+:24] <= a;
    i_write_data[16*p+:16] <= d;
  endtask

  // Timing of one chip select
  task automatic cfg(input int c, input logic [3:0] ini, acc, tl, tr, pc);
    @(posedge i_clock);
    i_initial_latency_rd[4*c+:4] <= ini;
    i_access_latency_rd[4*c+:4] <= acc;
    i_write_tail_cycles[4*c+:4] <= tl;
    i_turnaround_cycles[4*c+:4] <= tr;
    i_precharge_cycles[4*c+:4] <= pc;
  endtask

  // Hold requests until taken, count busy cycles until idle again
  task automatic go(input logic [2:0] mask);
    logic [2:0] acc;
    logic       bz;
    int         k;
    k = 0;
    nb = 0;
    @(posedge i_clock);
    i_request <= mask;
    repeat (300)
    begin
      @(negedge i_clock);
      acc = o_accept;
      bz = o_busy;
      nb = nb + int'(bz === 1'b1);
      for (int p = 0; p < 3; p++)
      begin
        if (o_read_valid[p] === 1'b1)
          rdat[p] = o_read_data;
        if (acc[p] === 1'b1)
        begin
          ord[2*k+:2] = 2'(p);
          k++;
        end
      end
      @(posedge i_clock);
      i_request <= i_request & ~acc;
      if ((i_request & ~acc) == 3'h0 && acc == 3'h0 && bz !== 1'b1 && nb > 0)
        break;
    end
  endtask

  // Single access on port 0 with its expected busy length
  task automatic one(input logic w, input logic [1:0] c, input logic [23:0] a,
                     input logic [15:0] d, input int ex);
    setp(0, w, c, a, d);
    go(3'h1);
    `CHK("busy cycles", ex, nb)
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    one(1'b0, 2'h0, 24'h10, 16'h0, 2);
    `CHK("read data", 16'h5A10, rdat[0])
    one(1'b1, 2'h0, 24'h10, 16'h1234, 3);
    cfg(1, 4'h2, 4'h1, 4'h2, 4'h3, 4'h2);
    one(1'b1, 2'h1, 24'h20, 16'hBEEF, 6);
    one(1'b0, 2'h1, 24'h20, 16'h0, 6);
    `CHK("read data", 16'hBEEF, rdat[0])
    one(1'b1, 2'h1, 24'h21, 16'hC0DE, 11);
    one(1'b0, 2'h1, 24'h21, 16'h0, 6);
    // Three masters at once, both processor orders
    for (int f = 0; f < 2; f++)
    begin
      @(posedge i_clock);
      i_processor1_first <= f[0];
      for (int p = 0; p < 3; p++)
        setp(p, 1'b0, 2'h2, 24'(p), 16'h0);
      go(3'h7);
      `CHK("grant order", (f ? 6'h21 : 6'h24), ord)
    end
    cfg(2, 4'h3, 4'h0, 4'h1, 4'h0, 4'h2);
    i_page_read_enable <= 4'h4;
    setp(0, 1'b0, 2'h2, 24'h30, 16'h0);
    setp(1, 1'b0, 2'h2, 24'h31, 16'h0);
    go(3'h3);
    `CHK("busy cycles", 7, nb)
    `CHK("read data", 16'h5AB1, rdat[1])
    cfg(3, 4'h1, 4'h0, 4'h1, 4'h0, 4'h0);
    i_page_write_enable <= 4'h8;
    setp(0, 1'b1, 2'h3, 24'h40, 16'h1111);
    setp(1, 1'b1, 2'h3, 24'h41, 16'h2222);
    go(3'h3);
    `CHK("busy cycles", 7, nb)
    one(1'b0, 2'h3, 24'h41, 16'h0, 2);
    `CHK("read data", 16'h2222, rdat[0])
    cfg(0, 4'h4, 4'h0, 4'h1, 4'h0, 4'h0);
    // Burst-capable select first used in asynchronous mode
    i_burst_capable <= 4'h1;
    i_addr_valid_idle_cycles <= 8'h02;
    one(1'b0, 2'h0, 24'h10, 16'h0, 7);
    `CHK("read data", 16'h1234, rdat[0])
    // Burst reads; same select and direction, so no idle cycles
    i_burst_read_enable <= 4'h1;
    one(1'b0, 2'h0, 24'h10, 16'h0, 5);
    `CHK("read data", 16'h1234, rdat[0])
    stall <= 4'h6;
    setp(0, 1'b0, 2'h0, 24'h11, 16'h0);
    go(3'h1);
    n1 = nb;
    stall <= 4'h0;
    setp(0, 1'b0, 2'h0, 24'h12, 16'h0);
    go(3'h1);
    `CHK("stall extends", 1'b1, n1 > nb)
    `CHK("stall busy", 10, n1)
    `CHK("busy cycles", 5, nb)
    // Registered config pin, idle level of select 0, divided burst clock
    cre <= 1'b1;
    lvl <= 4'hE;
    @(negedge i_clock);
    bclk = o_burst_memory_clock;
    @(negedge i_clock);
    `CHK("config enable", 1'b1, o_pseudo_static_config_enable)
    `CHK("idle level", 1'b0, o_addr_valid_strobe_n)
    `CHK("burst clock", ~bclk, o_burst_memory_clock)
    end_sim;
  end
endmodule

bind smc_core smc_checker u_smc_checker
(
  .i_clock, .i_reset, .i_request, .i_processor1_first, .o_accept, .o_read_valid,
  .o_chip_select_n, .o_output_enable_n, .o_write_enable_n, .o_data_oe,
  .o_addr_valid_strobe_n, .o_busy, .i_burst_capable, .i_burst_read_enable
);

`default_nettype wire
